// ---- core/ufm_baud.sv ----
// Baud timer: selectable prescaler and 16-bit reload timer giving overflow ticks
`timescale 1ns/1ps
`default_nettype none
`include "ufm_defs.svh"
module ufm_baud
    import ufm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic restart,
    input wire logic [1:0] presc_sel,
    input wire logic [15:0] reload,
    output logic ovf
);
    logic [5:0] presc_r;
    logic [15:0] tmr_r;
    logic ovf_r;
    logic tick;

    function automatic logic [5:0] presc_limit(input logic [1:0] sel);
        logic [5:0] l;
        unique case (sel)
            2'h0: l = `UFM_PS_12;
            2'h1: l = `UFM_PS_4;
            2'h2: l = `UFM_PS_48;
            2'h3: l = `UFM_PS_1;
        endcase
        return l;
    endfunction : presc_limit

    assign tick = (presc_r == presc_limit(presc_sel));
    assign ovf = ovf_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            presc_r <= 6'h00;
        end else if (restart || !enable || tick) begin
            presc_r <= 6'h00;
        end else begin
            presc_r <= presc_r + 6'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tmr_r <= `UFM_RELOAD_RST;
        end else if (restart || !enable) begin
            tmr_r <= reload;
        end else if (tick) begin
            tmr_r <= (tmr_r == `UFM_TMR_MAX) ? reload : tmr_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ovf_r <= 1'b0;
        end else begin
            ovf_r <= enable && !restart && tick && (tmr_r == `UFM_TMR_MAX);
        end
    end
endmodule : ufm_baud
`default_nettype wire

// ---- core/ufm_defs.svh ----
// Register map, field positions, reset values and timing constants of the serial port
`ifndef UFM_DEFS_SVH
`define UFM_DEFS_SVH

`define UFM_ADR_DATA 8'h00
`define UFM_ADR_CTRL 8'h04
`define UFM_ADR_FMT 8'h08
`define UFM_ADR_RELOAD 8'h0c
`define UFM_ADR_BAUD 8'h10

`define UFM_C_OVR 7
`define UFM_C_PERR 6
`define UFM_C_THRE 5
`define UFM_C_REN 4
`define UFM_C_TBX 3
`define UFM_C_RBX 2
`define UFM_C_TI 1
`define UFM_C_RI 0

`define UFM_F_MCE 7
`define UFM_F_PT 6:5
`define UFM_F_PE 4
`define UFM_F_LEN 3:2
`define UFM_F_XBE 1
`define UFM_F_STOP2 0
`define UFM_FMT_RST 8'h0c

`define UFM_B_IRQEN 7
`define UFM_B_EN 6
`define UFM_B_PS 1:0
`define UFM_BAUD_RST 8'h00
`define UFM_RELOAD_RST 16'h0000

`define UFM_PS_1 6'h00
`define UFM_PS_4 6'h03
`define UFM_PS_12 6'h0b
`define UFM_PS_48 6'h2f
`define UFM_TMR_MAX 16'hffff

`define UFM_LEN5 2'h0
`define UFM_MIN_BITS 4'h5
`define UFM_PT_ODD 2'h0
`define UFM_PT_EVEN 2'h1
`define UFM_PT_MARK 2'h2
`define UFM_PT_SPACE 2'h3

`define UFM_FIFO_DEPTH 2'h3
`define UFM_PTR_LAST 2'h2
`define UFM_CNT_ONE 2'h1

`endif

// ---- core/ufm_pkg.sv ----
// Types and shared functions of the serial port
`include "ufm_defs.svh"
package ufm_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP} ufm_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} ufm_rx_state_t;

    // Number of data bits for a length code
    function automatic logic [3:0] ufm_char_bits(input logic [1:0] code);
        return `UFM_MIN_BITS + {2'h0, code};
    endfunction : ufm_char_bits

    function automatic logic ufm_parity(input logic [7:0] d, input logic [1:0] code,
                                        input logic [1:0] pt);
        logic x;
        logic p;
        x = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < ufm_char_bits(code)) begin
                x = x ^ d[i];
            end
        end
        unique case (pt)
            `UFM_PT_ODD: p = ~x;
            `UFM_PT_EVEN: p = x;
            `UFM_PT_MARK: p = 1'b1;
            `UFM_PT_SPACE: p = 1'b0;
        endcase
        return p;
    endfunction : ufm_parity
endpackage : ufm_pkg

// ---- core/ufm_rx_fifo.sv ----
// Three-entry receive FIFO holding data byte and extra bit
`timescale 1ns/1ps
`default_nettype none
`include "ufm_defs.svh"
module ufm_rx_fifo
    import ufm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic push,
    input wire logic [8:0] push_data,
    input wire logic pop,
    output logic [8:0] head,
    output logic [1:0] count,
    output logic full,
    output logic empty
);
    logic [8:0] mem [0:2];
    logic [1:0] wr_ptr_r;
    logic [1:0] rd_ptr_r;
    logic [1:0] count_r;
    logic do_push;
    logic do_pop;

    function automatic logic [1:0] ptr_inc(input logic [1:0] p);
        return (p == `UFM_PTR_LAST) ? 2'h0 : p + 2'h1;
    endfunction : ptr_inc

    assign full = (count_r == `UFM_FIFO_DEPTH);
    assign empty = (count_r == 2'h0);
    assign count = count_r;
    assign head = mem[rd_ptr_r];
    assign do_push = push && !full;
    assign do_pop = pop && !empty;

    // Entries start cleared so status bits read defined values
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `UFM_FIFO_DEPTH; i++) begin
                mem[i] <= 9'h000;
            end
        end else if (do_push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= 2'h0;
            rd_ptr_r <= 2'h0;
            count_r <= 2'h0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (do_pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            count_r <= count_r + {1'b0, do_push} - {1'b0, do_pop};
        end
    end
endmodule : ufm_rx_fifo
`default_nettype wire

// ---- core/ufm_top.sv ----
// Serial port core: Wishbone registers, transmitter, receiver and multiprocessor filter
//
// Overview of operation
// - Frame: low start, data LSB first, optional parity/extra bit, high stops.
// - Character length of five to eight data bits, both directions.
// - Parity generated and checked as even, odd, mark or space.
// - One or two stop bits selectable.
// - Second stop bit only for six to eight bit characters.
// - Parity enabled disables extra bit; the slot carries parity.
// - Data write loads holding register and clears holding-empty flag.
// - Double buffering: held byte waits for the running frame to end.
// - Transmit-done set at start of stop time; interrupt if enabled.
// - Extra bit without parity sends the transmit extra-bit control.
// - Parity bit computed from selected type, appended after data.
// - Receiver starts only when enabled; FIFO stays readable when disabled.
// - Byte stored after stop only if FIFO not full and stops high.
// - Byte completing into full FIFO is dropped and sets overrun.
// - Frame with low stop bit is not stored.
// - Storing sets receive flag; multiprocessor mode needs extra bit one.
// - Data read returns oldest byte, frees entry, next byte follows.
// - Receive flag clear works only when no further bytes wait.
// - Receive extra-bit status shows extra bit, else stop bit value.
// - Parity mismatch sets parity error; only software clears it.
// - Baud timer counts up from reload, reloads on overflow.
// - Baud prescaler divides system clock by 1, 4, 12 or 48.
`timescale 1ns/1ps
`default_nettype none
`include "ufm_defs.svh"
module ufm_top
    import ufm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic uart_irq
);
    // Register state
    logic ovr_r, perr_r, thre_r, ren_r, tbx_r, ti_r, ri_r;
    logic [7:0] fmt_r;
    logic [7:0] bcon_r;
    logic [15:0] reload_r;
    logic [7:0] hold_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic irq_r;

    // Bus decode
    logic acc, wr_data, wr_ctrl, wr_fmt, wr_bcon, rd_data;
    assign acc = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_data = acc && wb_we_i && wb_sel_i[0] && (wb_adr_i == `UFM_ADR_DATA);
    assign wr_ctrl = acc && wb_we_i && wb_sel_i[0] && (wb_adr_i == `UFM_ADR_CTRL);
    assign wr_fmt = acc && wb_we_i && wb_sel_i[0] && (wb_adr_i == `UFM_ADR_FMT);
    assign wr_bcon = acc && wb_we_i && wb_sel_i[0] && (wb_adr_i == `UFM_ADR_BAUD);
    assign rd_data = acc && !wb_we_i && (wb_adr_i == `UFM_ADR_DATA);

    // Format fields
    logic mce, pe, xbe, extra_en, slot_en, two_stop, baud_en;
    logic [1:0] pt, len;
    logic [3:0] nbits;
    assign mce = fmt_r[`UFM_F_MCE];
    assign pt = fmt_r[`UFM_F_PT];
    assign pe = fmt_r[`UFM_F_PE];
    assign len = fmt_r[`UFM_F_LEN];
    assign xbe = fmt_r[`UFM_F_XBE];
    assign nbits = ufm_char_bits(len);
    assign extra_en = xbe && !pe;
    assign slot_en = pe || xbe;
    // No second stop at five bits
    assign two_stop = fmt_r[`UFM_F_STOP2] && (len != `UFM_LEN5);
    assign baud_en = bcon_r[`UFM_B_EN];

    // Receive FIFO
    logic push, pop, fifo_full, fifo_empty;
    logic [8:0] push_data, head;
    logic [1:0] fifo_count;
    ufm_rx_fifo u_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .push(push),
        .push_data(push_data),
        .pop(pop),
        .head(head),
        .count(fifo_count),
        .full(fifo_full),
        .empty(fifo_empty)
    );
    assign pop = rd_data && !fifo_empty;

    // Baud timers, one per direction
    logic tx_load, tx_ovf, rx_restart, rx_ovf;
    ufm_baud u_tx_baud (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .enable(baud_en),
        .restart(tx_load),
        .presc_sel(bcon_r[`UFM_B_PS]),
        .reload(reload_r),
        .ovf(tx_ovf)
    );
    ufm_baud u_rx_baud (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .enable(baud_en),
        .restart(rx_restart),
        .presc_sel(bcon_r[`UFM_B_PS]),
        .reload(reload_r),
        .ovf(rx_ovf)
    );

    // Transmitter
    ufm_tx_state_t tx_state_r;
    logic [7:0] tx_shift_r;
    logic [3:0] tx_cnt_r;
    logic tx_phase_r, tx_x_r, tx_stop2_r, tx_out_r, tx_bit_end, ti_set;
    // Move held byte only when idle
    assign tx_load = (tx_state_r == TX_IDLE) && !thre_r && baud_en;
    assign tx_bit_end = tx_ovf && tx_phase_r;
    assign ti_set = tx_bit_end && (((tx_state_r == TX_DATA) && !slot_en
                    && (tx_cnt_r == nbits - 4'h1)) || (tx_state_r == TX_EXTRA));
    assign serial_out_pin = tx_out_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_phase_r <= 1'b0;
        end else if (tx_load) begin
            tx_phase_r <= 1'b0;
        end else if (tx_ovf) begin
            tx_phase_r <= !tx_phase_r;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_state_r <= TX_IDLE;
            tx_shift_r <= 8'h00;
            tx_cnt_r <= 4'h0;
            tx_x_r <= 1'b0;
            tx_stop2_r <= 1'b0;
            tx_out_r <= 1'b1;
        end else begin
            unique case (tx_state_r)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_shift_r <= hold_r;
                        tx_x_r <= pe ? ufm_parity(hold_r, len, pt) : tbx_r;
                        tx_stop2_r <= two_stop;
                        tx_out_r <= 1'b0;
                        tx_state_r <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_bit_end) begin
                        tx_out_r <= tx_shift_r[0];
                        tx_cnt_r <= 4'h0;
                        tx_state_r <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_bit_end) begin
                        if (tx_cnt_r == nbits - 4'h1) begin
                            tx_out_r <= slot_en ? tx_x_r : 1'b1;
                            tx_state_r <= slot_en ? TX_EXTRA : TX_STOP;
                        end else begin
                            tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                            tx_out_r <= tx_shift_r[1];
                            tx_cnt_r <= tx_cnt_r + 4'h1;
                        end
                    end
                end
                TX_EXTRA: begin
                    if (tx_bit_end) begin
                        tx_out_r <= 1'b1;
                        tx_state_r <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_bit_end) begin
                        if (tx_stop2_r) begin
                            tx_stop2_r <= 1'b0;
                        end else begin
                            tx_state_r <= TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Receiver input synchroniser and edge detect
    logic rx_s1_r, rx_s2_r, rx_prev_r, rx_fall;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_s1_r <= serial_in_pin;
            rx_s2_r <= rx_s1_r;
            rx_prev_r <= rx_s2_r;
        end
    end
    assign rx_fall = rx_prev_r && !rx_s2_r;

    ufm_rx_state_t rx_state_r;
    logic [7:0] rx_data_r;
    logic [3:0] rx_cnt_r;
    logic rx_phase_r, rx_x_r, rx_ok_r, rx_stop2_r, rx_samp, rx_done, rx_ok;
    logic ovr_set, perr_set, ri_set;
    assign rx_restart = (rx_state_r == RX_IDLE) && rx_fall && ren_r && baud_en;
    assign rx_samp = rx_ovf && !rx_phase_r;
    assign rx_done = rx_samp && (rx_state_r == RX_STOP) && !rx_stop2_r;
    assign rx_ok = rx_ok_r && rx_s2_r;
    // Store only when room and stops high
    assign push = rx_done && rx_ok && !fifo_full;
    // Extra bit or stop bit stored with byte
    assign push_data = {extra_en ? rx_x_r : 1'b1, rx_data_r};
    assign ovr_set = rx_done && rx_ok && fifo_full;
    assign perr_set = push && pe && (rx_x_r != ufm_parity(rx_data_r, len, pt));
    assign ri_set = push && (!mce || push_data[8]);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_phase_r <= 1'b0;
        end else if (rx_restart) begin
            rx_phase_r <= 1'b0;
        end else if (rx_ovf) begin
            rx_phase_r <= !rx_phase_r;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_state_r <= RX_IDLE;
            rx_data_r <= 8'h00;
            rx_cnt_r <= 4'h0;
            rx_x_r <= 1'b0;
            rx_ok_r <= 1'b1;
            rx_stop2_r <= 1'b0;
        end else begin
            unique case (rx_state_r)
                RX_IDLE: begin
                    if (rx_restart) begin
                        rx_data_r <= 8'h00;
                        rx_cnt_r <= 4'h0;
                        rx_ok_r <= 1'b1;
                        rx_stop2_r <= two_stop;
                        rx_state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_samp) begin
                        rx_state_r <= rx_s2_r ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_samp) begin
                        rx_data_r[rx_cnt_r[2:0]] <= rx_s2_r;
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_cnt_r == nbits - 4'h1) begin
                            rx_state_r <= slot_en ? RX_EXTRA : RX_STOP;
                        end
                    end
                end
                RX_EXTRA: begin
                    if (rx_samp) begin
                        rx_x_r <= rx_s2_r;
                        rx_state_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_samp) begin
                        rx_ok_r <= rx_ok;
                        rx_stop2_r <= 1'b0;
                        if (!rx_stop2_r) begin
                            rx_state_r <= RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Transmit holding register and empty flag
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hold_r <= 8'h00;
            thre_r <= 1'b1;
        end else if (wr_data) begin
            hold_r <= wb_dat_i[7:0];
            thre_r <= 1'b0;
        end else if (tx_load) begin
            thre_r <= 1'b1;
        end
    end

    // Control flags: hardware set wins over software write
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ovr_r <= 1'b0;
            perr_r <= 1'b0;
            ren_r <= 1'b0;
            tbx_r <= 1'b0;
            ti_r <= 1'b0;
            ri_r <= 1'b0;
        end else begin
            ovr_r <= ovr_set || (wr_ctrl ? wb_dat_i[`UFM_C_OVR] : ovr_r);
            perr_r <= perr_set || (wr_ctrl ? wb_dat_i[`UFM_C_PERR] : perr_r);
            ti_r <= ti_set || (wr_ctrl ? wb_dat_i[`UFM_C_TI] : ti_r);
            ri_r <= ri_set || (wr_ctrl ? (wb_dat_i[`UFM_C_RI]
                    || (ri_r && (fifo_count > `UFM_CNT_ONE))) : ri_r);
            if (wr_ctrl) begin
                ren_r <= wb_dat_i[`UFM_C_REN];
                tbx_r <= wb_dat_i[`UFM_C_TBX];
            end
        end
    end

    // Format, baud control and reload registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fmt_r <= `UFM_FMT_RST;
            bcon_r <= `UFM_BAUD_RST;
            reload_r <= `UFM_RELOAD_RST;
        end else begin
            if (wr_fmt) begin
                fmt_r <= wb_dat_i[7:0];
            end
            if (wr_bcon) begin
                bcon_r <= wb_dat_i[7:0];
            end
            if (acc && wb_we_i && (wb_adr_i == `UFM_ADR_RELOAD)) begin
                if (wb_sel_i[0]) begin
                    reload_r[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    reload_r[15:8] <= wb_dat_i[15:8];
                end
            end
        end
    end

    // Bus answer and read data
    logic [7:0] ctrl_rd;
    assign ctrl_rd = {ovr_r, perr_r, thre_r, ren_r, tbx_r, head[8], ti_r, ri_r};
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= acc;
            if (acc && !wb_we_i) begin
                unique case (wb_adr_i)
                    `UFM_ADR_DATA: dat_r <= {24'h00_0000, head[7:0]};
                    `UFM_ADR_CTRL: dat_r <= {24'h00_0000, ctrl_rd};
                    `UFM_ADR_FMT: dat_r <= {24'h00_0000, fmt_r};
                    `UFM_ADR_RELOAD: dat_r <= {16'h0000, reload_r};
                    `UFM_ADR_BAUD: dat_r <= {24'h00_0000, bcon_r};
                    default: dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Interrupt on transmit done or receive flag
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= bcon_r[`UFM_B_IRQEN] && (ti_r || ri_r);
        end
    end
    assign uart_irq = irq_r;
endmodule : ufm_top
`default_nettype wire

// ---- verification/ufm_assertions.sv ----
// Port checker of the serial port core
`timescale 1ns/1ps
`default_nettype none
module ufm_assertions (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic serial_out_pin,
    input wire logic uart_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    AST_ACK_NEXT: assert property (req |=> wb_ack_o)
        else $error("no ack after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_REQ: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    AST_HIGH_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_UNMAPPED: assert property (req && !wb_we_i && wb_adr_i > 8'h10 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_RST_IDLE: assert property ($rose(resetn) |-> serial_out_pin && !uart_irq)
        else $error("line not idle after reset");
    AST_START_LEN: assert property ($fell(serial_out_pin) |-> !serial_out_pin[*8] ##20 !serial_out_pin)
        else $error("start bit too short");
    AST_BIT_HOLD: assert property ($changed(serial_out_pin) |=> $stable(serial_out_pin)[*8] ##20 $stable(serial_out_pin))
        else $error("bit time too short");
    cover property ($fell(serial_out_pin));
    cover property (req && !wb_we_i && wb_adr_i == 8'h00);
    cover property ($rose(uart_irq));
endmodule : ufm_assertions
bind ufm_top ufm_assertions u_chk (.ref_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .serial_out_pin, .uart_irq);
`default_nettype wire

// ---- verification/ufm_peer.sv ----
// Remote serial node model on the two serial pins
`timescale 1ns/1ps
`default_nettype none
module ufm_peer #(parameter int BIT = 32) (
    input wire logic ref_clk,
    input wire logic line_in,
    output logic line_out
);
    initial line_out = 1'b1;
    task automatic bt(input logic v);
        line_out <= v;
        repeat (BIT) @(posedge ref_clk);
    endtask : bt
    task automatic send(input logic [7:0] d, input int n, input logic so, input logic sl,
                        input logic s1, input logic s2);
        bt(1'b0);
        for (int i = 0; i < n; i++) bt(d[i]);
        if (so) bt(sl);
        bt(s1);
        bt(s2);
        line_out <= 1'b1;
        @(posedge ref_clk);
    endtask : send
    task automatic recv(output logic [7:0] d, output logic sl, input int n, input logic so);
        d = 8'h00;
        sl = 1'b0;
        while (line_in !== 1'b0) @(posedge ref_clk);
        repeat (BIT / 2) @(posedge ref_clk);
        for (int i = 0; i <= n; i++) begin
            repeat (BIT) @(posedge ref_clk);
            if (i < n) d[i] = line_in;
            else if (so) sl = line_in;
        end
        while (line_in !== 1'b1) @(posedge ref_clk);
    endtask : recv
endmodule : ufm_peer
`default_nettype wire

// ---- verification/ufm_top_tb.sv ----
// Self-checking bench of the serial port core
`timescale 1ns/1ps
`default_nettype none
`include "ufm_defs.svh"
module ufm_top_tb;
    localparam logic [7:0] DA = `UFM_ADR_DATA;
    localparam logic [7:0] CT = `UFM_ADR_CTRL;
    logic ref_clk = 1'b0, resetn = 1'b0, cyc = 1'b0, we = 1'b0, rx, tx, irq, ack, gs, es, so;
    logic [7:0] adr = 8'h00, g, m;
    logic [31:0] wd = 32'h0, rd, dat_o;
    int n, n_fail = 0, comparisons = 0;
    logic [7:0] fm [6] = '{8'h00, 8'h15, 8'h38, 8'h5c, 8'h7c, 8'h0e};
    logic [7:0] dt [6] = '{8'h15, 8'h2b, 8'h4d, 8'h96, 8'h69, 8'hc3};
    ufm_top dut (.ref_clk, .resetn, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .serial_in_pin(rx), .serial_out_pin(tx), .uart_irq(irq));
    ufm_peer p (.ref_clk, .line_in(tx), .line_out(rx));
    initial forever #2 ref_clk = ~ref_clk;
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge ref_clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
    endtask : wb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rc
    task automatic cb(input int b, input logic v);
        wb(1'b0, CT, 32'h0);
        chk({31'h0, rd[b]}, {31'h0, v});
    endtask : cb
    function automatic logic slot(input logic [7:0] d, input logic [7:0] f, input logic x);
        logic p;
        p = ^(d & (8'hff >> (3 - f[3:2])));
        if (!f[4]) return x;
        return f[6:5] == 2'h0 ? ~p : f[6:5] == 2'h1 ? p : ~f[5];
    endfunction : slot
    task automatic results;
        $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    initial begin
        #400000;
        n_fail++;
        results;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        rc(CT, 32'h20);
        rc(`UFM_ADR_FMT, 32'h0c);
        rc(8'h14, 32'h0);
        wb(1'b1, `UFM_ADR_RELOAD, 32'hfff0);
        wb(1'b1, `UFM_ADR_BAUD, 32'hc3);
        wb(1'b1, CT, 32'h10);
        fork
            begin
                wb(1'b1, DA, 32'ha5);
                wb(1'b1, DA, 32'h3c);
                cb(5, 1'b0);
            end
            begin
                p.recv(g, gs, 8, 1'b0);
                chk(g, 32'ha5);
                p.recv(g, gs, 8, 1'b0);
                chk(g, 32'h3c);
            end
        join
        chk(irq, 1'b1);
        wb(1'b1, `UFM_ADR_BAUD, 32'h43);
        cb(1, 1'b1);
        chk(irq, 1'b0);
        for (int r = 0; r < 6; r++) begin
            n = 5 + fm[r][3:2];
            m = 8'hff >> (3 - fm[r][3:2]);
            so = fm[r][4] | fm[r][1];
            es = slot(dt[r], fm[r], r == 5);
            wb(1'b1, `UFM_ADR_FMT, {24'h0, fm[r]});
            wb(1'b1, CT, r == 5 ? 32'h18 : 32'h10);
            fork
                wb(1'b1, DA, {24'h0, dt[r]});
                p.recv(g, gs, n, so);
            join
            chk(g, dt[r] & m);
            chk(gs, es);
            p.send(dt[r], n, so, es, 1'b1, 1'b1);
            cb(0, 1'b1);
            rc(DA, dt[r] & m);
            wb(1'b1, CT, 32'h10);
            p.send(dt[r], n, so, ~es, 1'b1, ~fm[r][0]);
            cb(0, ~fm[r][0]);
            cb(6, fm[r][4] & ~fm[r][0]);
            wb(1'b0, DA, 32'h0);
        end
        wb(1'b1, `UFM_ADR_FMT, 32'h0c);
        wb(1'b1, CT, 32'h10);
        for (int i = 1; i < 5; i++) p.send(8'(i * 17), 8, 1'b0, 1'b0, 1'b1, 1'b1);
        cb(7, 1'b1);
        for (int i = 1; i < 4; i++) begin
            wb(1'b1, CT, 32'h10);
            cb(0, i < 3);
            rc(DA, 8'(i * 17));
        end
        wb(1'b1, CT, 32'h00);
        p.send(8'h5a, 8, 1'b0, 1'b0, 1'b1, 1'b1);
        cb(0, 1'b0);
        wb(1'b1, `UFM_ADR_FMT, 32'h8e);
        wb(1'b1, CT, 32'h10);
        p.send(8'h42, 8, 1'b1, 1'b0, 1'b1, 1'b1);
        cb(0, 1'b0);
        p.send(8'h81, 8, 1'b1, 1'b1, 1'b1, 1'b1);
        cb(0, 1'b1);
        cb(2, 1'b0);
        rc(DA, 32'h42);
        cb(2, 1'b1);
        wb(1'b1, `UFM_ADR_RELOAD, 32'hfffc);
        wb(1'b1, `UFM_ADR_BAUD, 32'h41);
        fork
            wb(1'b1, DA, 32'h96);
            p.recv(g, gs, 8, 1'b1);
        join
        chk(g, 32'h96);
        chk(gs, 1'b0);
        results;
    end
endmodule : ufm_top_tb
`default_nettype wire
